//--- logic/scr_defines.svh
// Purpose: constants shared by both ends of the serial continuous-read link
// Assumes: included by its bare name; definitions only
// Notes: Operation list follows
//
// Operation
// - frame opens at chip select fall, opcode, address
// - each clock shifts one bit in while selected
// - everything travels most significant bit first
// - buffer byte picked by ten-bit index
// - array location is 13-bit page, 10-bit byte
// - opcode E8 starts the continuous read
// - 24-bit address: reserved, page, byte
// - 32 dummy clocks, then data on output
// - internal address counter advances by itself
// - host keeps chip select low whole frame
// - page end rolls into next page seamlessly
// - array end wraps to first page seamlessly
// - chip select rise ends read, output floats
// - read never modifies either SRAM buffer
// - array holds 8192 pages of 528 bytes
// - two independent 528-byte SRAM buffers exist
// - works in clock mode 0 and 3
// - program whole pages, erase page or block
// - program and erase are self-timed internally
// - busy shown while self-timed operation runs
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// =====================================================
// command and frame layout
`define SCR_OPC_CONT_READ 8'hE8
`define SCR_OPC_BITS      8
`define SCR_ADDR_BITS     24
`define SCR_DUMMY_BITS    32
`define SCR_OPC_LAST      7'h07
`define SCR_ADDR_END      7'h20
`define SCR_HDR_END       7'h40

// =====================================================
// array geometry
`define SCR_PAGE_W        13
`define SCR_BYTE_W        10
`define SCR_PAGES         8192
`define SCR_PAGE_BYTES    528
`define SCR_LAST_PAGE     13'h1FFF
`define SCR_LAST_BYTE     10'h20F
`define SCR_BUF_BYTES     528
`define SCR_BUF_COUNT     2
`define SCR_BLOCK_PAGES   8
`define SCR_BLOCK_BYTES   4224

// =====================================================
// host link timing, in host clocks per half link period
`define SCR_HALF_DIV      5

`endif

//--- logic/scr_pkg.sv
// Purpose: shared types of the continuous-read link
// Assumes: scr_defines.svh supplies the numbers
// Notes: none
`default_nettype none
`include "scr_defines.svh"
package scr_pkg;
   typedef logic [`SCR_PAGE_W-1:0] scr_page_t;
   typedef logic [`SCR_BYTE_W-1:0] scr_byte_t;
   typedef logic [9:0]             scr_buf_idx_t;
   typedef enum logic [2:0] {SCR_IDLE, SCR_LEAD, SCR_BITS, SCR_TAIL, SCR_GAP} scr_host_st_t;
endpackage
`default_nettype wire

//--- logic/scr_link_if.sv
// Purpose: four-wire serial link between host and memory end
// Assumes: the memory end floats its output while deselected
// Notes: a weak pull-up is modelled as a high level when nobody drives
`timescale 1ns/100ps
`default_nettype none
interface scr_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so_d;
   logic so_oe;
   logic so;

   // resolved serial output; undriven line rests high
   assign so = so_oe ? so_d : 1'b1;

   modport dev  (input cs_n, input sck, input si, output so_d, output so_oe);
   modport host (output cs_n, output sck, output si, input so);
endinterface
`default_nettype wire

//--- logic/scr_dev.sv
// Purpose: memory end of the link, continuous array read command front end
// Assumes: array data comes from a port fed by page and byte address
// Notes: link logic runs on the serial clock; status runs on clk_i
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.svh"
module scr_dev
   import scr_pkg::*;
(
   // link to the host
   scr_link_if.dev             link,
   // system clock and reset
   input  wire logic           clk_i,
   input  wire logic           resetn_i,
   // self-timed program and erase engine
   input  wire logic           busy_i,
   output logic                rdy_busy_n_o,
   // main array read port
   output scr_pkg::scr_page_t  mem_page_o,
   output scr_pkg::scr_byte_t  mem_byte_o,
   input  wire logic [7:0]     mem_rdata_i,
   // buffer write strobes, one per buffer
   output logic [`SCR_BUF_COUNT-1:0] buf_we_o
);
   import scr_pkg::*;

   // =====================================================
   // geometry checks
   // the address fields must reach every page and every byte of a page
   if ((1 << `SCR_PAGE_W) != `SCR_PAGES || `SCR_LAST_BYTE != `SCR_PAGE_BYTES - 1)
   begin : g_geo_chk
      $error("array geometry and address fields disagree");
   end

   // a buffer index must reach every byte of either buffer
   if ((1 << $bits(scr_buf_idx_t)) < `SCR_BUF_BYTES)
   begin : g_buf_chk
      $error("buffer index too narrow");
   end

   // erase blocks are whole pages; programming acts on single pages
   if (`SCR_BLOCK_PAGES * `SCR_PAGE_BYTES != `SCR_BLOCK_BYTES)
   begin : g_blk_chk
      $error("erase block size disagrees with page size");
   end

   // =====================================================
   // frame reset
   // a deselected device is held in reset, so decode always
   // restarts from bit zero and the output floats at once
   logic arst_n;
   assign arst_n = resetn_i & ~link.cs_n;

   // =====================================================
   // status domain
   // busy level comes from the engine on clk_i, same domain
   logic busy_r;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         busy_r       <= 1'b0;
         rdy_busy_n_o <= 1'b1;
      end
      else
      begin
         busy_r       <= busy_i;
         rdy_busy_n_o <= ~busy_i;
      end
   end

   // =====================================================
   // busy crossing into the link domain
   // three stages; a change counts once stages two and three agree.
   // the serial clock stops between frames, so the value can be stale
   // for the first edges of a frame; the opcode edge comes later
   logic bsy_s1_r;
   logic bsy_s2_r;
   logic bsy_s3_r;
   logic bsy_seen_r;

   always_ff @(posedge link.sck or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bsy_s1_r   <= 1'b0;
         bsy_s2_r   <= 1'b0;
         bsy_s3_r   <= 1'b0;
         bsy_seen_r <= 1'b0;
      end
      else
      begin
         bsy_s1_r <= busy_r;
         bsy_s2_r <= bsy_s1_r;
         bsy_s3_r <= bsy_s2_r;
         if (bsy_s2_r == bsy_s3_r)
         begin
            bsy_seen_r <= bsy_s3_r;
         end
      end
   end

   // =====================================================
   // header capture on rising clock edges
   // hdr_cnt_r counts rising edges and stops at the data phase
   logic [6:0]  hdr_cnt_r;
   logic [31:0] hdr_sh_r;
   logic        op_ok_r;
   logic [7:0]  opc_w;

   // opcode as it stands on the eighth rising edge
   assign opc_w = {hdr_sh_r[6:0], link.si};

   always_ff @(posedge link.sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hdr_cnt_r <= 7'h00;
      end
      else if (hdr_cnt_r < `SCR_HDR_END)
      begin
         hdr_cnt_r <= hdr_cnt_r + 7'h01;
      end
   end

   // opcode then address, shifted in msb first
   always_ff @(posedge link.sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hdr_sh_r <= 32'h0000_0000;
      end
      else if (hdr_cnt_r < `SCR_ADDR_END)
      begin
         hdr_sh_r <= {hdr_sh_r[30:0], link.si};
      end
   end

   // only the continuous read opcode arms the read path; a busy
   // device refuses it, since the array is not readable then
   always_ff @(posedge link.sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         op_ok_r <= 1'b0;
      end
      else if (hdr_cnt_r == `SCR_OPC_LAST)
      begin
         op_ok_r <= (opc_w == `SCR_OPC_CONT_READ) && !bsy_seen_r;
      end
   end

   // =====================================================
   // address fields of the 24-bit address
   // bit 23 is reserved, then page, then starting byte
   scr_page_t start_page_w;
   scr_byte_t start_byte_w;

   assign start_page_w = hdr_sh_r[`SCR_ADDR_BITS-2:`SCR_BYTE_W];
   assign start_byte_w = hdr_sh_r[`SCR_BYTE_W-1:0];

   // next array location: page end rolls over, array end wraps.
   // a start byte past the page end is treated as the last byte
   function automatic logic [`SCR_PAGE_W+`SCR_BYTE_W-1:0] scr_next
      (input scr_page_t pg, input scr_byte_t by);
   begin
      if (by < `SCR_LAST_BYTE)
      begin
         scr_next = {pg, by + 10'h001};
      end
      else if (pg == `SCR_LAST_PAGE)
      begin
         scr_next = {13'h0000, 10'h000};
      end
      else
      begin
         scr_next = {pg + 13'h0001, 10'h000};
      end
   end
   endfunction

   // =====================================================
   // data path on falling clock edges
   // the array port gets the address during the dummy cycles, so
   // the first byte has settled long before it is needed; later
   // bytes are fetched eight clocks ahead of their first bit
   logic       in_dummy_w;
   logic       in_data_w;
   logic [2:0] bit_pos_r;
   logic [7:0] out_sh_r;

   assign in_dummy_w = op_ok_r && (hdr_cnt_r >= `SCR_ADDR_END) && (hdr_cnt_r < `SCR_HDR_END);
   assign in_data_w  = op_ok_r && (hdr_cnt_r == `SCR_HDR_END);

   // array address counter
   always_ff @(negedge link.sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_page_o <= 13'h0000;
         mem_byte_o <= 10'h000;
      end
      else if (in_dummy_w)
      begin
         mem_page_o <= start_page_w;
         mem_byte_o <= start_byte_w;
      end
      else if (in_data_w && bit_pos_r == 3'h0)
      begin
         {mem_page_o, mem_byte_o} <= scr_next(mem_page_o, mem_byte_o);
      end
   end

   // serial output, msb of each byte first, no gap between bytes;
   // driving on falling edges and sampling on rising ones serves
   // an idle-low and an idle-high link clock alike
   always_ff @(negedge link.sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_pos_r  <= 3'h0;
         out_sh_r   <= 8'h00;
         link.so_d  <= 1'b0;
         link.so_oe <= 1'b0;
      end
      else if (in_data_w)
      begin
         link.so_oe <= 1'b1;
         bit_pos_r  <= bit_pos_r + 3'h1;
         if (bit_pos_r == 3'h0)
         begin
            link.so_d <= mem_rdata_i[7];
            out_sh_r  <= {mem_rdata_i[6:0], 1'b0};
         end
         else
         begin
            link.so_d <= out_sh_r[7];
            out_sh_r  <= {out_sh_r[6:0], 1'b0};
         end
      end
   end

   // =====================================================
   // buffer protection
   // this front end reads the array only; the buffer strobes
   // are held off so a read can never disturb buffer contents
   always_ff @(posedge link.sck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         buf_we_o <= '0;
      end
      else
      begin
         buf_we_o <= '0;
      end
   end

endmodule
`default_nettype wire

//--- logic/scr_host.sv
// Purpose: host end, issues continuous array reads and collects bytes
// Assumes: the link clock is made here by dividing clk_i
// Notes: MODE3 selects an idle-high clock; sampling is the same in both
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.svh"
module scr_host
   import scr_pkg::*;
#(
   parameter int HALF_DIV = `SCR_HALF_DIV,
   parameter bit MODE3    = 1'b0
)
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          resetn_i,
   // link to the memory end
   scr_link_if.host           link,
   // read request
   input  wire logic          start_i,
   input  wire scr_pkg::scr_page_t page_i,
   input  wire scr_pkg::scr_byte_t byte_i,
   input  wire logic [15:0]   len_i,
   // read answer
   output logic               busy_o,
   output logic [7:0]         data_o,
   output logic               data_valid_o
);
   import scr_pkg::*;

   // the output sync needs three clocks inside one half period
   if (HALF_DIV < 5 || HALF_DIV > 255)
   begin : g_chk
      $error("HALF_DIV out of range");
   end

   localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
   localparam logic       SCK_IDLE = MODE3;

   // =====================================================
   // serial output input sync, three stages
   logic so_s1_r;
   logic so_s2_r;
   logic so_s3_r;
   logic so_held_r;
   logic so_w;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         so_s1_r   <= 1'b1;
         so_s2_r   <= 1'b1;
         so_s3_r   <= 1'b1;
         so_held_r <= 1'b1;
      end
      else
      begin
         so_s1_r <= link.so;
         so_s2_r <= so_s1_r;
         so_s3_r <= so_s2_r;
         if (so_s2_r == so_s3_r)
         begin
            so_held_r <= so_s3_r;
         end
      end
   end

   // accepted level: new value once stages two and three agree
   assign so_w = (so_s2_r == so_s3_r) ? so_s3_r : so_held_r;

   // =====================================================
   // sequencer
   scr_host_st_t st_r;
   logic [7:0]   div_r;
   logic         tick_w;
   logic [63:0]  hdr_r;
   logic [6:0]   hdr_cnt_r;
   logic [2:0]   rbit_r;
   logic [7:0]   rx_r;
   logic [15:0]  len_r;

   assign tick_w = (div_r == DIV_LAST);

   // half-period divider, restarted after every tick and held clear in SCR_IDLE
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         div_r <= 8'h00;
      end
      else if (st_r == SCR_IDLE || tick_w)
      begin
         div_r <= 8'h00;
      end
      else
      begin
         div_r <= div_r + 8'h01;
      end
   end

   // chip select stays low from opcode to the last data bit
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_r         <= SCR_IDLE;
         link.cs_n    <= 1'b1;
         link.sck     <= 1'b0;
         link.si      <= 1'b0;
         hdr_r        <= 64'h0000_0000_0000_0000;
         hdr_cnt_r    <= 7'h00;
         rbit_r       <= 3'h0;
         rx_r         <= 8'h00;
         len_r        <= 16'h0000;
         busy_o       <= 1'b0;
         data_o       <= 8'h00;
         data_valid_o <= 1'b0;
      end
      else
      begin
         data_valid_o <= 1'b0;
         unique case (st_r)
            SCR_IDLE:
            begin
               link.sck <= SCK_IDLE;
               if (start_i && len_i != 16'h0000)
               begin
                  // opcode, reserved bit, page, byte, dummy clocks
                  hdr_r     <= {`SCR_OPC_CONT_READ, 1'b0, page_i, byte_i, 32'h0000_0000};
                  len_r     <= len_i;
                  hdr_cnt_r <= 7'h00;
                  rbit_r    <= 3'h0;
                  link.cs_n <= 1'b0;
                  busy_o    <= 1'b1;
                  st_r      <= SCR_LEAD;
               end
            end
            SCR_LEAD:
            begin
               if (tick_w)
               begin
                  link.sck <= 1'b0;
                  link.si  <= hdr_r[63];
                  st_r     <= SCR_BITS;
               end
            end
            SCR_BITS:
            begin
               if (tick_w && !link.sck)
               begin
                  link.sck <= 1'b1;
                  if (hdr_cnt_r == `SCR_HDR_END)
                  begin
                     rx_r   <= {rx_r[6:0], so_w};
                     rbit_r <= rbit_r + 3'h1;
                     if (rbit_r == 3'h7)
                     begin
                        data_o       <= {rx_r[6:0], so_w};
                        data_valid_o <= 1'b1;
                        len_r        <= len_r - 16'h0001;
                     end
                  end
               end
               else if (tick_w)
               begin
                  if (hdr_cnt_r != `SCR_HDR_END)
                  begin
                     link.sck  <= 1'b0;
                     hdr_r     <= {hdr_r[62:0], 1'b0};
                     link.si   <= hdr_r[62];
                     hdr_cnt_r <= hdr_cnt_r + 7'h01;
                  end
                  else if (len_r == 16'h0000)
                  begin
                     link.sck <= SCK_IDLE;
                     st_r     <= SCR_TAIL;
                  end
                  else
                  begin
                     link.sck <= 1'b0;
                  end
               end
            end
            SCR_TAIL:
            begin
               if (tick_w)
               begin
                  link.cs_n <= 1'b1;
                  st_r      <= SCR_GAP;
               end
            end
            SCR_GAP:
            begin
               if (tick_w)
               begin
                  busy_o <= 1'b0;
                  st_r   <= SCR_IDLE;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

//--- tb/scr_link_assertions.sv
// Purpose: concurrent checks on the host-to-memory serial link
// Assumes: host half period of 5 clk_i cycles, memory end never busy
// Notes: rising link clocks are counted, cleared while deselected
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.svh"
module scr_link_assertions
(
   // system clock domain
   input wire logic clk_i,
   input wire logic resetn_i,
   // link wires
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_d,
   input wire logic so_oe,
   input wire logic so
);
   localparam logic [7:0] OPC = `SCR_OPC_CONT_READ;
   logic [19:0]           cnt_r;

   // ==========================================
   // helper: async clear so each frame counts from zero
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
         cnt_r <= 20'h0_0000;
      else
         cnt_r <= cnt_r + 20'h0_0001;
   end

   // ==========================================
   // header bits and output drive on the wire, sampled at each rising link clock
   chk_opcode_msb: assert property (@(posedge sck) disable iff (cs_n)
      (cnt_r < 20'h0_0008) |-> (si == OPC[3'h7 - cnt_r[2:0]])) else $error("opcode bit wrong");
   chk_reserved_low: assert property (@(posedge sck) disable iff (cs_n)
      (cnt_r == 20'h0_0008) |-> !si) else $error("reserved bit not low");
   chk_dummy_zero: assert property (@(posedge sck) disable iff (cs_n)
      (cnt_r >= 20'h0_0020 && cnt_r < 20'h0_0040) |-> !si) else $error("dummy bit not low");
   chk_quiet_header: assert property (@(posedge sck) disable iff (cs_n)
      (cnt_r < 20'h0_0040) |-> !so_oe) else $error("output driven in header");
   chk_data_driven: assert property (@(posedge sck) disable iff (cs_n)
      (cnt_r >= 20'h0_0040) |-> (so_oe && so == so_d)) else $error("output not driven in data");

   // ==========================================
   // framing, seen from the system clock
   chk_float_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cs_n |-> (!so_oe && so)) else $error("output driven while deselected");
   chk_idle_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cs_n |-> !sck) else $error("link clock not idle low");
   chk_half_period: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(sck) |-> sck [*5] ##1 !sck) else $error("high half not five cycles");
   chk_whole_bytes: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(cs_n) |-> ($past(cnt_r) >= 20'h0_0048 && ($past(cnt_r) & 20'h0_0007) == 20'h0_0000))
      else $error("frame closed early or mid-byte");

   // ==========================================
   // main scenarios reached
   cov_three_bytes: cover property (@(posedge sck) disable iff (cs_n) cnt_r == 20'h0_0058);
   cov_drive_start: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(so_oe));
   cov_frame_end: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(cs_n));
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: host and memory ends face to face, plus a bench-driven second link
// Assumes: array contents come from a fixed pattern function
// Notes: second link breaks host rules on purpose and runs mode 0 and mode 3
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.svh"
module tb_top;
   import scr_pkg::*;
   localparam time HB = 32; // half of the 64 ns bench link clock
   logic clk_i, resetn_i, start_i, busy_b;
   logic [15:0] len_i;
   scr_page_t   page_i, pg_a, pg_b;
   scr_byte_t   byte_i, by_a, by_b;
   logic [7:0]  data_o;
   logic        busy_o, data_valid_o, rdy_a, rdy_b;
   logic [1:0]  we_a, we_b;
   logic [63:0] hdr_a;
   int          err_count, total_checks, cyc, bits_a;

   scr_link_if link_a();
   scr_link_if link_b();

   // pattern differs between neighbouring bytes and pages
   function automatic logic [7:0] mem_val(input int pg, input int by);
      return 8'((pg * 3 + by) & 255);
   endfunction

   scr_host #(.HALF_DIV(5), .MODE3(1'b0)) i_scr_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link_a),
      .start_i(start_i), .page_i(page_i), .byte_i(byte_i), .len_i(len_i), .busy_o(busy_o),
      .data_o(data_o), .data_valid_o(data_valid_o));
   scr_dev i_scr_dev (.link(link_a), .clk_i(clk_i), .resetn_i(resetn_i), .busy_i(1'b0),
      .rdy_busy_n_o(rdy_a), .mem_page_o(pg_a), .mem_byte_o(by_a), .mem_rdata_i(mem_val(pg_a, by_a)),
      .buf_we_o(we_a));
   scr_dev i_scr_dev_b (.link(link_b), .clk_i(clk_i), .resetn_i(resetn_i), .busy_i(busy_b),
      .rdy_busy_n_o(rdy_b), .mem_page_o(pg_b), .mem_byte_o(by_b), .mem_rdata_i(mem_val(pg_b, by_b)),
      .buf_we_o(we_b));
   scr_link_assertions i_chk (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n(link_a.cs_n), .sck(link_a.sck),
      .si(link_a.si), .so_d(link_a.so_d), .so_oe(link_a.so_oe), .so(link_a.so));

   // ==========================================
   // clock, cycle count, header capture on the first link
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   always @(posedge link_a.sck or posedge link_a.cs_n)
   begin
      if (link_a.cs_n)
         bits_a <= 0;
      else if (bits_a < 64)
      begin
         hdr_a <= {hdr_a[62:0], link_a.si};
         bits_a <= bits_a + 1;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step(inout int pg, inout int by);
      if (by >= `SCR_PAGE_BYTES - 1)
      begin
         by = 0;
         pg = (pg + 1) % `SCR_PAGES;
      end
      else
         by++;
   endtask

   // one host read; byte spacing must stay constant across any boundary
   task automatic run_read(input int pg, input int by, input int len);
      int n;
      int last;
      last = 0;
      page_i = 13'(pg);
      byte_i = 10'(by);
      len_i = 16'(len);
      start_i = 1'b1;
      @(posedge clk_i);
      #1 start_i = 1'b0;
      check(32'(busy_o), 32'h0000_0001);
      for (int b = 0; b < len; b++)
      begin
         n = 0;
         do
         begin
            @(posedge clk_i);
            #1 n++;
         end
         while (data_valid_o !== 1'b1 && n < 2000);
         check(32'(data_valid_o), 32'h0000_0001);
         check(32'(data_o), 32'(mem_val(pg, by)));
         if (b > 0) check(32'(cyc - last), 32'h0000_0050);
         last = cyc;
         step(pg, by);
      end
      n = 0;
      while (busy_o !== 1'b0 && n < 200)
      begin
         @(posedge clk_i);
         #1 n++;
      end
      check(32'(busy_o), 32'h0000_0000);
   endtask

   // bench acts as host on the second link; ends with a mid-byte abort
   task automatic xfer_b(input logic [7:0] opc, input int pg, input int by, input int nb, input bit m3,
                         input bit ok);
      logic [63:0] hdr;
      logic [7:0]  got;
      hdr = {opc, 1'b0, 13'(pg), 10'(by), 32'h0000_0000};
      link_b.sck = m3;
      #HB link_b.cs_n = 1'b0;
      for (int i = 0; i < 64; i++)
      begin
         link_b.sck = 1'b0;
         link_b.si = hdr[63 - i];
         #HB link_b.sck = 1'b1;
         #HB;
      end
      for (int i = 0; i < nb * 8 + 3; i++)
      begin
         link_b.sck = 1'b0;
         link_b.si = ~link_b.si; // keep a stale level from passing
         #HB got = {got[6:0], link_b.so};
         link_b.sck = 1'b1;
         #HB;
         if (i % 8 == 7)
         begin
            check(32'(got), ok ? 32'(mem_val(pg, by)) : 32'h0000_00FF);
            step(pg, by);
         end
      end
      link_b.sck = m3;
      #HB link_b.cs_n = 1'b1;
      #HB check(32'(link_b.so_oe), 32'h0000_0000);
   endtask

   // ==========================================
   // scenarios, one task each
   task automatic test_basic;
      run_read(5, 0, 3);
      check(hdr_a[63:32], {8'hE8, 1'b0, 13'h0005, 10'h000});
      check(hdr_a[31:0], 32'h0000_0000);
      $display("test done: basic read");
   endtask

   task automatic test_page_cross;
      run_read(9, 526, 4);
      $display("test done: page crossing");
   endtask

   task automatic test_wrap;
      run_read(8191, 526, 3);
      $display("test done: array wrap");
   endtask

   task automatic test_mode3_abort;
      xfer_b(`SCR_OPC_CONT_READ, 3, 526, 3, 1'b1, 1'b1);
      $display("test done: mode 3 read with abort");
   endtask

   task automatic test_foreign_opc;
      xfer_b(8'hD2, 3, 0, 2, 1'b0, 1'b0);
      $display("test done: foreign opcode");
   endtask

   // busy level changes just after a system clock edge
   task automatic test_busy;
      @(posedge clk_i);
      #1 busy_b = 1'b1;
      repeat (3) @(posedge clk_i);
      #1 check(32'(rdy_b), 32'h0000_0000);
      xfer_b(`SCR_OPC_CONT_READ, 100, 0, 2, 1'b0, 1'b0);
      @(posedge clk_i);
      #1 busy_b = 1'b0;
      repeat (3) @(posedge clk_i);
      #1 check(32'(rdy_b), 32'h0000_0001);
      xfer_b(`SCR_OPC_CONT_READ, 100, 0, 2, 1'b0, 1'b1);
      $display("test done: busy refusal");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      {clk_i, resetn_i, start_i, busy_b, len_i, page_i, byte_i} = '0;
      {link_b.cs_n, link_b.sck, link_b.si} = 3'b100;
      {err_count, total_checks, cyc} = '0;
      repeat (5) @(posedge clk_i);
      #1 resetn_i = 1'b1;
      @(posedge clk_i);
      #1 check(32'({rdy_a, rdy_b}), 32'h0000_0003);
      test_basic;
      test_page_cross;
      test_wrap;
      test_mode3_abort;
      test_foreign_opc;
      test_busy;
      check(32'({we_a, we_b}), 32'h0000_0000);
      finish_test;
   end

   // watchdog: whole run needs well under a quarter of this
   initial
   begin
      #1_000_000;
      err_count++;
      finish_test;
   end
endmodule
`default_nettype wire
